// >>> qu_pkg.sv
// Shared constants for the four-channel UART host front end and baud generators
package qu_pkg;

  // ==========================================================================
  // Structure
  localparam int NUM_CH   = 4;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int LVL_W    = 7;
  localparam int FRAC_W   = 4;
  localparam int DIV_W    = 16;
  localparam int SYNC_LEN = 3;

  // ==========================================================================
  // Address decode
  localparam int CFG_SPACE_BIT  = 7;
  localparam int CH_IDX_LSB     = 4;
  localparam int CH_IDX_W       = 3;
  localparam int REG_OFS_W      = 4;

  // Per-channel register offsets (address bits 3:0)
  localparam logic [3:0] CH_DIV_LO    = 4'h0;
  localparam logic [3:0] CH_DIV_HI    = 4'h1;
  localparam logic [3:0] CH_DIV_FRAC  = 4'h2;
  localparam logic [3:0] CH_MODEM_CTL = 4'h3;
  localparam logic [3:0] CH_FIFO_CTL  = 4'h4;
  localparam logic [3:0] CH_SAMP_MODE = 4'h5;
  localparam logic [3:0] CH_HDX_CTL   = 4'h6;
  localparam logic [3:0] CH_TX_TRIG   = 4'h7;
  localparam logic [3:0] CH_RX_TRIG   = 4'h8;
  localparam logic [3:0] CH_STATUS    = 4'h9;

  // Shared configuration register offsets (address bits 3:0, top bit set)
  localparam logic [3:0] CFG_SOFT_RESET = 4'h0;
  localparam logic [3:0] CFG_BROADCAST  = 4'h1;

  // ==========================================================================
  // Field positions
  localparam int MCR_PRESCALE_BIT = 7;
  localparam int FCR_FIFO_EN_BIT  = 0;
  localparam int BCAST_EN_BIT     = 0;
  localparam int SAMP_8X_BIT      = 0;
  localparam int HDX_AUTO_BIT     = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] DIV_LO_RST   = 8'h01;
  localparam logic [7:0] DIV_HI_RST   = 8'h00;
  localparam logic [7:0] DIV_FRAC_RST = 8'h00;
  localparam logic [7:0] MCR_RST      = 8'h00;
  localparam logic [7:0] FCR_RST      = 8'h00;
  localparam logic [7:0] SAMP_RST     = 8'h00;
  localparam logic [7:0] HDX_RST      = 8'h00;
  localparam logic [7:0] TX_TRIG_RST  = 8'h20;
  localparam logic [7:0] RX_TRIG_RST  = 8'h20;
  localparam logic [7:0] BCAST_RST    = 8'h00;

  // ==========================================================================
  // Timing
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [3:0] LAST_SAMP_16X = 4'hF;
  localparam logic [3:0] LAST_SAMP_8X  = 4'h7;

  typedef enum logic [1:0] {
    QU_IDLE,
    QU_WRITE,
    QU_READ
  } qu_bus_state_type;

endpackage

// >>> qu_baud_gen.sv
// Per-channel prescaler and fractional baud generator
module qu_baud_gen
  import qu_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              soft_rst_i,
  input  wire logic              prescale4_i,
  input  wire logic [DIV_W-1:0]  div_int_i,
  input  wire logic [FRAC_W-1:0] div_frac_i,
  input  wire logic              eight_x_i,
  output logic                   sample_tick_o,
  output logic                   bit_tick_o
);

  logic [1:0]        pre_cnt;
  logic              pre_en;
  logic [DIV_W-1:0]  per_cnt;
  logic [FRAC_W-1:0] frac_acc;
  logic [FRAC_W:0]   frac_sum;
  logic [DIV_W-1:0]  div_eff;
  logic [DIV_W:0]    next_per;
  logic [3:0]        samp_cnt;
  logic [3:0]        samp_last;

  // ==========================================================================
  // Prescaler
  assign pre_en = prescale4_i ? (pre_cnt == PRESCALE_LAST) : 1'b1; // see RULE10

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_cnt <= 2'h0;
    end else if (soft_rst_i) begin
      pre_cnt <= 2'h0;
    end else begin
      pre_cnt <= pre_cnt + 2'h1; // see RULE10
    end
  end

  // ==========================================================================
  // Fractional divider
  // Zero integer is clamped to one so the generator never stalls
  assign div_eff  = (div_int_i == '0) ? DIV_W'(1) : div_int_i;
  assign frac_sum = {1'b0, frac_acc} + {1'b0, div_frac_i};
  // Carry stretches one period, averaging int + frac/16; see RULE11 RULE15
  assign next_per = {1'b0, div_eff} - (DIV_W+1)'(1) + (DIV_W+1)'(frac_sum[FRAC_W]);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      per_cnt       <= '0;
      frac_acc      <= '0;
      sample_tick_o <= 1'b0;
    end else if (soft_rst_i) begin
      per_cnt       <= '0;
      frac_acc      <= '0;
      sample_tick_o <= 1'b0;
    end else begin
      sample_tick_o <= 1'b0;
      if (pre_en) begin
        if (per_cnt == '0) begin
          per_cnt       <= next_per[DIV_W-1:0]; // see RULE11
          frac_acc      <= frac_sum[FRAC_W-1:0];
          sample_tick_o <= 1'b1;
        end else begin
          per_cnt <= per_cnt - DIV_W'(1);
        end
      end
    end
  end

  // ==========================================================================
  // Bit timing
  // Odd fractions spread carries unevenly over 8 ticks, giving +/- 1/16 jitter
  assign samp_last = eight_x_i ? LAST_SAMP_8X : LAST_SAMP_16X; // see RULE16 RULE17

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      samp_cnt   <= 4'h0;
      bit_tick_o <= 1'b0;
    end else if (soft_rst_i) begin
      samp_cnt   <= 4'h0;
      bit_tick_o <= 1'b0;
    end else begin
      bit_tick_o <= 1'b0;
      if (sample_tick_o) begin
        if (samp_cnt >= samp_last) begin
          samp_cnt   <= 4'h0;
          bit_tick_o <= 1'b1; // see RULE12
        end else begin
          samp_cnt <= samp_cnt + 4'h1;
        end
      end
    end
  end

endmodule // qu_baud_gen

// >>> qu_host_front.sv
// Host bus front end: channel select, broadcast writes, interrupt levels, clocks
// Function
// RULE1: Soft-reset register write restores channel register defaults
// RULE2: Channel access only while chip select low
// RULE3: Top bit zero: index bits pick channel 0-3
// RULE4: Broadcast bit set: writes reach all four channels
// RULE5: Host clears broadcast before reads, avoids active channels
// RULE6: Tx level high above trigger, normal direction
// RULE7: Tx level low when transmitter empty, auto direction
// RULE8: Rx level high below trigger or no data
// RULE9: One clock drives all generators and logic
// RULE10: Prescaler per channel divides by 1 or 4
// RULE11: Divisor one to 65535.9375 in sixteenths
// RULE12: Tx and rx use the generated sampling clock
// RULE13: Divisor resets to one: 01, 00, 00
// RULE14: Integer divisor split into high and low bytes
// RULE15: Only four fraction bits implemented, sixteenths
// RULE16: Eight-times sampling doubles the data rate
// RULE17: Odd fraction in 8X gives 1/16 jitter
// RULE18: Software computes divisor from clock and rate
// RULE19: Hardware reset low restores all defaults
// RULE20: Top bit one reaches shared configuration registers
module qu_host_front
  import qu_pkg::*;
(
  input  wire logic                        core_clk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        cs_n_i,
  input  wire logic                        wr_n_i,
  input  wire logic                        rd_n_i,
  input  wire logic [ADDR_W-1:0]           addr_i,
  input  wire logic [DATA_W-1:0]           data_i,
  output logic      [DATA_W-1:0]           data_o,
  output logic                             data_oe_o,
  input  wire logic [NUM_CH-1:0][LVL_W-1:0] tx_level_i,
  input  wire logic [NUM_CH-1:0][LVL_W-1:0] rx_level_i,
  input  wire logic [NUM_CH-1:0]           tx_empty_i,
  input  wire logic [NUM_CH-1:0]           rx_held_i,
  output logic      [NUM_CH-1:0]           tx_int_o,
  output logic      [NUM_CH-1:0]           rx_int_o,
  output logic      [NUM_CH-1:0]           sample_tick_o,
  output logic      [NUM_CH-1:0]           bit_tick_o,
  output logic      [NUM_CH-1:0]           prescale4_o,
  output logic      [NUM_CH-1:0]           eight_x_sampling_sel_o
);

  localparam int SYNC_W = 3 + ADDR_W + DATA_W;

  // ==========================================================================
  // Pin synchronisers
  logic [SYNC_W-1:0]    sync1;
  logic [SYNC_W-1:0]    sync2;
  logic [SYNC_W-1:0]    sync3;
  logic [SYNC_W-1:0]    pins_stable;
  logic                 cs_n_s;
  logic                 wr_n_s;
  logic                 rd_n_s;
  logic [ADDR_W-1:0]    addr_s;
  logic [DATA_W-1:0]    data_s;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1       <= {3'h7, {(ADDR_W+DATA_W){1'b0}}};
      sync2       <= {3'h7, {(ADDR_W+DATA_W){1'b0}}};
      sync3       <= {3'h7, {(ADDR_W+DATA_W){1'b0}}};
      pins_stable <= {3'h7, {(ADDR_W+DATA_W){1'b0}}};
    end else begin
      sync1 <= {cs_n_i, wr_n_i, rd_n_i, addr_i, data_i};
      sync2 <= sync1;
      sync3 <= sync2;
      // A bit counts only once stages two and three agree
      for (int b = 0; b < SYNC_W; b++) begin
        if (sync2[b] == sync3[b]) begin
          pins_stable[b] <= sync3[b];
        end
      end
    end
  end

  assign {cs_n_s, wr_n_s, rd_n_s, addr_s, data_s} = pins_stable;

  // ==========================================================================
  // Address decode
  logic                 cfg_space;
  logic [CH_IDX_W-1:0]  ch_idx;
  logic                 ch_valid;
  logic [1:0]           ch_sel;
  logic [REG_OFS_W-1:0] reg_ofs;

  assign cfg_space = addr_s[CFG_SPACE_BIT]; // see RULE20
  assign ch_idx    = addr_s[CH_IDX_LSB +: CH_IDX_W];
  assign ch_valid  = ~cfg_space & (ch_idx < CH_IDX_W'(NUM_CH)); // see RULE3
  assign ch_sel    = ch_idx[1:0]; // see RULE3
  assign reg_ofs   = addr_s[REG_OFS_W-1:0];

  // ==========================================================================
  // Bus access sequencer
  qu_bus_state_type state;
  logic             wr_go;
  logic             rd_go;

  // Each access acts once, on the first stable cycle of the strobe
  assign wr_go = (state == QU_IDLE) & ~cs_n_s & ~wr_n_s; // see RULE2
  assign rd_go = (state == QU_IDLE) & ~cs_n_s & ~rd_n_s & wr_n_s; // see RULE2

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= QU_IDLE;
    end else begin
      unique case (state)
        QU_IDLE: begin
          if (wr_go) begin
            state <= QU_WRITE;
          end else if (rd_go) begin
            state <= QU_READ;
          end
        end
        QU_WRITE: begin
          if (wr_n_s | cs_n_s) begin
            state <= QU_IDLE;
          end
        end
        QU_READ: begin
          if (rd_n_s | cs_n_s) begin
            state <= QU_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Shared configuration registers
  logic [DATA_W-1:0] bcast_reg;
  logic [NUM_CH-1:0] soft_rst;
  logic              cfg_wr;

  assign cfg_wr = wr_go & cfg_space; // see RULE20

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bcast_reg <= BCAST_RST; // see RULE19
    end else if (cfg_wr && reg_ofs == CFG_BROADCAST) begin
      bcast_reg <= data_s;
    end
  end

  // One bit per channel; a write pulses reset for the channels whose bits are set
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      soft_rst <= '0;
    end else if (cfg_wr && reg_ofs == CFG_SOFT_RESET) begin
      soft_rst <= data_s[NUM_CH-1:0]; // see RULE1
    end else begin
      soft_rst <= '0;
    end
  end

  // ==========================================================================
  // Channel registers
  logic [NUM_CH-1:0] ch_wr;
  logic [DATA_W-1:0] div_lo   [NUM_CH];
  logic [DATA_W-1:0] div_hi   [NUM_CH];
  logic [DATA_W-1:0] div_frac [NUM_CH];
  logic [DATA_W-1:0] modem_control_reg      [NUM_CH];
  logic [DATA_W-1:0] fifo_control_reg      [NUM_CH];
  logic [DATA_W-1:0] samp     [NUM_CH];
  logic [DATA_W-1:0] hdx      [NUM_CH];
  logic [DATA_W-1:0] tx_trig  [NUM_CH];
  logic [DATA_W-1:0] rx_trig  [NUM_CH];

  // Broadcast ignores the index bits but still needs a channel address
  always_comb begin
    ch_wr = '0;
    if (wr_go && !cfg_space) begin
      if (bcast_reg[BCAST_EN_BIT]) begin
        ch_wr = '1; // see RULE4
      end else if (ch_valid) begin
        ch_wr[ch_sel] = 1'b1; // see RULE3
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        div_lo[c]   <= DIV_LO_RST; // see RULE13 RULE19
        div_hi[c]   <= DIV_HI_RST;
        div_frac[c] <= DIV_FRAC_RST;
        modem_control_reg[c]      <= MCR_RST;
        fifo_control_reg[c]      <= FCR_RST;
        samp[c]     <= SAMP_RST;
        hdx[c]      <= HDX_RST;
        tx_trig[c]  <= TX_TRIG_RST;
        rx_trig[c]  <= RX_TRIG_RST;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (soft_rst[c]) begin
          div_lo[c]   <= DIV_LO_RST; // see RULE1 RULE13
          div_hi[c]   <= DIV_HI_RST;
          div_frac[c] <= DIV_FRAC_RST;
          modem_control_reg[c]      <= MCR_RST;
          fifo_control_reg[c]      <= FCR_RST;
          samp[c]     <= SAMP_RST;
          hdx[c]      <= HDX_RST;
          tx_trig[c]  <= TX_TRIG_RST;
          rx_trig[c]  <= RX_TRIG_RST;
        end else if (ch_wr[c]) begin
          unique case (reg_ofs)
            CH_DIV_LO:    div_lo[c]   <= data_s; // see RULE14
            CH_DIV_HI:    div_hi[c]   <= data_s; // see RULE14
            // Upper fraction bits are not stored and read back as zero
            CH_DIV_FRAC:  div_frac[c] <= {4'h0, data_s[FRAC_W-1:0]}; // see RULE15
            CH_MODEM_CTL: modem_control_reg[c]      <= data_s;
            CH_FIFO_CTL:  fifo_control_reg[c]      <= data_s;
            CH_SAMP_MODE: samp[c]     <= data_s;
            CH_HDX_CTL:   hdx[c]      <= data_s;
            CH_TX_TRIG:   tx_trig[c]  <= data_s;
            CH_RX_TRIG:   rx_trig[c]  <= data_s;
            default: ;
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // Interrupt levels
  function automatic logic above_trig(input logic [LVL_W-1:0] lvl, input logic [DATA_W-1:0] trig);
    above_trig = {1'b0, lvl} > trig;
  endfunction

  function automatic logic below_trig(input logic [LVL_W-1:0] lvl, input logic [DATA_W-1:0] trig);
    below_trig = {1'b0, lvl} < trig;
  endfunction

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_int_o <= '0;
      rx_int_o <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (fifo_control_reg[c][FCR_FIFO_EN_BIT]) begin
          if (hdx[c][HDX_AUTO_BIT]) begin
            // Auto direction: held low only once the shifter has drained
            tx_int_o[c] <= above_trig(tx_level_i[c], tx_trig[c]) & ~tx_empty_i[c]; // see RULE7
          end else begin
            tx_int_o[c] <= above_trig(tx_level_i[c], tx_trig[c]); // see RULE6
          end
          rx_int_o[c] <= below_trig(rx_level_i[c], rx_trig[c]); // see RULE8
        end else begin
          tx_int_o[c] <= 1'b0;
          rx_int_o[c] <= ~rx_held_i[c]; // see RULE8
        end
      end
    end
  end

  // ==========================================================================
  // Read path
  function automatic logic [DATA_W-1:0] ch_read(input logic [1:0] c, input logic [REG_OFS_W-1:0] ofs);
    unique case (ofs)
      CH_DIV_LO:    ch_read = div_lo[c];
      CH_DIV_HI:    ch_read = div_hi[c];
      CH_DIV_FRAC:  ch_read = div_frac[c];
      CH_MODEM_CTL: ch_read = modem_control_reg[c];
      CH_FIFO_CTL:  ch_read = fifo_control_reg[c];
      CH_SAMP_MODE: ch_read = samp[c];
      CH_HDX_CTL:   ch_read = hdx[c];
      CH_TX_TRIG:   ch_read = tx_trig[c];
      CH_RX_TRIG:   ch_read = rx_trig[c];
      CH_STATUS:    ch_read = {4'h0, tx_empty_i[c], rx_held_i[c], tx_int_o[c], rx_int_o[c]};
      default:      ch_read = 8'h00;
    endcase
  endfunction

  logic [DATA_W-1:0] rd_val;

  always_comb begin
    rd_val = 8'h00;
    if (cfg_space) begin
      if (reg_ofs == CFG_BROADCAST) begin
        rd_val = bcast_reg; // see RULE20
      end
    end else if (ch_valid) begin
      rd_val = ch_read(ch_sel, reg_ofs); // see RULE3
    end
  end

  // Drive only while a read is in progress so the bus stays free otherwise
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      if (rd_go) begin
        data_o <= rd_val; // see RULE2
      end
      data_oe_o <= rd_go | ((state == QU_READ) & ~rd_n_s & ~cs_n_s);
    end
  end

  // ==========================================================================
  // Baud generators
  logic [NUM_CH-1:0] prescale4;
  logic [NUM_CH-1:0] eight_x;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      prescale4[c] = modem_control_reg[c][MCR_PRESCALE_BIT]; // see RULE10
      eight_x[c]   = samp[c][SAMP_8X_BIT]; // see RULE16
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prescale4_o            <= '0;
      eight_x_sampling_sel_o <= '0;
    end else begin
      prescale4_o            <= prescale4;
      eight_x_sampling_sel_o <= eight_x;
    end
  end

  // Every channel runs from the one core clock; see RULE9
  for (genvar g = 0; g < NUM_CH; g++) begin : g_baud
    qu_baud_gen u_baud (
      .core_clk_i    (core_clk_i),
      .resetn_i      (resetn_i),
      .soft_rst_i    (soft_rst[g]),
      .prescale4_i   (prescale4[g]),
      .div_int_i     ({div_hi[g], div_lo[g]}),
      .div_frac_i    (div_frac[g][FRAC_W-1:0]),
      .eight_x_i     (eight_x[g]),
      .sample_tick_o (sample_tick_o[g]),
      .bit_tick_o    (bit_tick_o[g])
    );
  end

endmodule // qu_host_front

// >>> qu_host_front_asserts.sv
// Port-level checker for the host front end, bound to its top module
module qu_host_front_asserts
  import qu_pkg::*;
(
  input wire logic                          core_clk_i,
  input wire logic                          resetn_i,
  input wire logic                          cs_n_i,
  input wire logic                          wr_n_i,
  input wire logic                          rd_n_i,
  input wire logic [DATA_W-1:0]             data_o,
  input wire logic                          data_oe_o,
  input wire logic [NUM_CH-1:0][LVL_W-1:0]  tx_level_i,
  input wire logic [NUM_CH-1:0]             tx_int_o,
  input wire logic [NUM_CH-1:0]             sample_tick_o,
  input wire logic [NUM_CH-1:0]             bit_tick_o,
  input wire logic [NUM_CH-1:0]             prescale4_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // ==========================================================================
  // Bus drive
  // Six idle samples cover the three-flop sync, the agreement stage and the output register
  sequence s_cs_idle;
    cs_n_i [*6];
  endsequence
  sequence s_rd_idle;
    rd_n_i [*6];
  endsequence
  sequence s_write_held;
    (!cs_n_i && !wr_n_i) [*6];
  endsequence

  a_cs_idle_quiet: assert property (s_cs_idle |-> !data_oe_o)
    else $error("data bus driven while deselected");
  a_read_released: assert property (s_rd_idle |-> !data_oe_o)
    else $error("data bus driven without read strobe");
  a_write_no_drive: assert property (s_write_held |-> !data_oe_o)
    else $error("data bus driven during write");
  a_drive_after_read: assert property ($rose(data_oe_o) |-> !cs_n_i && !rd_n_i
                                       && !$past(cs_n_i, 2) && !$past(rd_n_i, 2))
    else $error("data bus driven without a held read");
  a_data_holds: assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o))
    else $error("read data changed while driven");

  // ==========================================================================
  // Baud timing and interrupt levels
  a_bit_gap_min: assert property (bit_tick_o[0] |=> (!bit_tick_o[0]) [*7])
    else $error("bit ticks closer than eight cycles");
  a_prescale_gap: assert property (sample_tick_o[0] && prescale4_o[0] && $past(prescale4_o[0], 8)
                                   |=> (!sample_tick_o[0] || !prescale4_o[0]) [*3])
    else $error("sample ticks closer than four cycles with prescaler");
  a_tx_int_level: assert property (tx_int_o[0] |-> $past(tx_level_i[0]) != 7'h00)
    else $error("transmit level high with empty fifo");
  a_tx_quiet_empty: assert property (tx_int_o[3] |-> $past(tx_level_i[3]) != 7'h00)
    else $error("transmit level high with empty fifo on last channel");
endmodule // qu_host_front_asserts

bind qu_host_front qu_host_front_asserts u_qu_host_front_asserts (
  .core_clk_i,
  .resetn_i,
  .cs_n_i,
  .wr_n_i,
  .rd_n_i,
  .data_o,
  .data_oe_o,
  .tx_level_i,
  .tx_int_o,
  .sample_tick_o,
  .bit_tick_o,
  .prescale4_o
);

// >>> qu_host_model.sv
// Behavioural host processor driving the parallel register bus
module qu_host_model
  import qu_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic [DATA_W-1:0] bus_data_i,
  input  wire logic              bus_oe_i,
  output logic                   cs_n_o,
  output logic                   wr_n_o,
  output logic                   rd_n_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      data_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    addr_o = 8'h00;
    data_o = 8'hA5;
  end

  task automatic access(input logic is_rd, input logic sel, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    int n;
    rd = 8'hEE;
    n = 0;
    @(posedge core_clk_i);
    #1;
    addr_o = a;
    data_o = wd;
    // Address must settle through the sync before the strobe falls
    repeat (3) @(posedge core_clk_i);
    #1;
    cs_n_o = !sel;
    rd_n_o = !is_rd;
    wr_n_o = is_rd;
    if (is_rd) begin
      do begin
        @(posedge core_clk_i);
        #1;
        n++;
      end while (bus_oe_i !== 1'b1 && n < 20);
      rd = bus_data_i;
      @(posedge core_clk_i);
      #1;
    end else begin
      repeat (8) @(posedge core_clk_i);
      #1;
    end
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
    // Released lines must not keep the last value
    addr_o = ~addr_o;
    data_o = ~data_o;
  endtask
endmodule // qu_host_model

// >>> quad_uart_host_select_and_baud_gen_test.sv
// Self-checking bench for the host front end with a reference register model
module quad_uart_host_select_and_baud_gen_test;
  import qu_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic                         clk;
  logic                         rst_n;
  logic                         cs_n, wr_n, rd_n, oe;
  logic [7:0]                   addr, wdat, bus, rdat;
  logic [NUM_CH-1:0][LVL_W-1:0] txl, rxl;
  logic [NUM_CH-1:0]            txe, rxh, txi, rxi, stk, btk, pre4, x8;
  int                           fails, check_count, bcast, n, e, t, p;
  int                           m[4][16];
  int                           cases[7][4] = '{'{3, 0, 0, 0}, '{258, 9, 0, 0}, '{1, 15, 0, 0}, '{5, 4, 1, 0},
                                               '{6, 6, 0, 1}, '{2, 2, 1, 1}, '{1, 3, 0, 1}};

  qu_host_front u_qu_host_front (
    .core_clk_i             (clk),
    .resetn_i               (rst_n),
    .cs_n_i                 (cs_n),
    .wr_n_i                 (wr_n),
    .rd_n_i                 (rd_n),
    .addr_i                 (addr),
    .data_i                 (wdat),
    .data_o                 (bus),
    .data_oe_o              (oe),
    .tx_level_i             (txl),
    .rx_level_i             (rxl),
    .tx_empty_i             (txe),
    .rx_held_i              (rxh),
    .tx_int_o               (txi),
    .rx_int_o               (rxi),
    .sample_tick_o          (stk),
    .bit_tick_o             (btk),
    .prescale4_o            (pre4),
    .eight_x_sampling_sel_o (x8)
  );

  qu_host_model u_qu_host_model (
    .core_clk_i (clk),
    .bus_data_i (bus),
    .bus_oe_i   (oe),
    .cs_n_o     (cs_n),
    .wr_n_o     (wr_n),
    .rd_n_o     (rd_n),
    .addr_o     (addr),
    .data_o     (wdat)
  );

  // ==========================================================================
  // Reference model and helpers
  function automatic void dflt(int c);
    m[c] = '{1, 0, 0, 0, 0, 0, 0, 32, 32, 0, 0, 0, 0, 0, 0, 0};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_qu_host_model.access(1'b0, 1'b1, a, d, rdat);
    for (int c = 0; c < NUM_CH; c++) begin
      if (a[7] && a[3:0] == CFG_SOFT_RESET && d[c]) dflt(c);
      if (!a[7] && (bcast != 0 || a[6:4] == c)) m[c][a[3:0]] = (a[3:0] == CH_DIV_FRAC) ? d & 8'h0F : d;
    end
    if (a[7] && a[3:0] == CFG_BROADCAST) bcast = d[0];
  endtask

  task automatic rd(input logic [7:0] a);
    u_qu_host_model.access(1'b1, 1'b1, a, 8'h00, rdat);
    check(rdat, a[6:4] < 4 ? m[a[6:4]][a[3:0]] : 0);
  endtask

  task automatic bit_gap(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (btk[0] !== 1'b1 && cnt < 20000);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    summarize();
  end

  // ==========================================================================
  // Tests
  initial begin
    rst_n = 1'b0;
    {txl, rxl, txe, rxh} = '0;
    bcast = 0;
    for (int c = 0; c < NUM_CH; c++) dflt(c);
    void'($urandom(32'h76a32209));
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check({pre4, x8}, 0);
    for (int q = 0; q < 3; q++) begin
      for (int c = 0; c < 12; c++) begin
        if (q == 1) wr({1'b0, 3'(c / 3), 4'(c % 3)}, 8'($urandom));
        else rd({1'b0, 3'(c / 3), 4'(c % 3)});
      end
    end
    rd(8'h50);
    u_qu_host_model.access(1'b0, 1'b0, 8'h00, 8'h5A, rdat);
    rd(8'h00);
    $display("test decode done");
    wr(8'h81, 8'h01);
    wr(8'h33, 8'h80);
    wr(8'h72, 8'h06);
    check(pre4, 4'hF);
    wr(8'h81, 8'h00);
    for (int c = 0; c < NUM_CH; c++) rd({1'b0, 3'(c), CH_DIV_FRAC});
    // Channel 0 still counts a random divisor; reset it so baud timing starts clean
    wr(8'h80, 8'h03);
    check(pre4, 4'hC);
    for (int c = 0; c < 6; c++) rd({1'b0, 3'(c / 3), 4'(c % 3)});
    $display("test broadcast done");
    foreach (cases[i]) begin
      wr(8'h00, 8'(cases[i][0]));
      wr(8'h01, 8'(cases[i][0] >> 8));
      wr(8'h02, 8'(cases[i][1]));
      wr(8'h03, cases[i][2] ? 8'h80 : 8'h00);
      wr(8'h05, 8'(cases[i][3]));
      check(x8[0], cases[i][3]);
      bit_gap(n);
      bit_gap(n);
      p = cases[i][2] ? 4 : 1;
      e = p * (16 * cases[i][0] + cases[i][1]);
      t = cases[i][3] ? 2 * n : n;
      if (cases[i][3] && cases[i][1] % 2) check(t == e - p || t == e + p, 1);
      else check(t, e);
    end
    $display("test baud done");
    wr(8'h04, 8'h01);
    wr(8'h34, 8'h01);
    wr(8'h07, 8'h10);
    for (int h = 0; h < 2; h++) begin
      wr(8'h06, 8'(h));
      repeat (24) begin
        @(posedge clk);
        #1;
        for (int c = 0; c < NUM_CH; c++) begin
          txl[c] = 7'($urandom_range(0, 40));
          rxl[c] = 7'($urandom_range(0, 40));
        end
        txe = 4'($urandom);
        rxh = 4'($urandom);
        repeat (2) @(posedge clk);
        #1;
        for (int c = 0; c < NUM_CH; c++) begin
          check(txi[c], m[c][4] % 2 && txl[c] > m[c][7] && !(m[c][6] % 2 && txe[c]));
          check(rxi[c], m[c][4] % 2 ? rxl[c] < m[c][8] : !rxh[c]);
        end
      end
    end
    $display("test interrupt levels done");
    summarize();
  end
endmodule // quad_uart_host_select_and_baud_gen_test
